// file: rtl/pisf_status_flags.sv
// Overview of operation
// (RL1) receive-error flag, bit 6, latches on event, resets 0, clears on read
// (RL2) page-received flag, bit 5, latches on page, resets 0, clears on read
// (RL3) parallel-detect-fault flag, bit 4, latches on fault, clears on read
// (RL4) partner-acknowledge flag, bit 3, latches on acknowledge, clears on read
// (RL5) link-down flag, bit 2, latches when link drops, clears on read
// (RL6) remote-fault flag, bit 1, latches on remote fault, clears on read
// (RL7) link-up flag, bit 0, latches when link comes up, clears on read
// (RL8) enable bits 15..8 are read-write, reset to 0
// (RL9) interrupt asserts while any enabled flag is set; read clears it
`include "pisf_consts.svh"

module pisf_status_flags
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire pisf_pkg::pisf_evt_t events,
  input wire pisf_pkg::pisf_req_t req,
  output logic [15:0] rdData,
  output logic irq
);
  import pisf_pkg::*;

  pisf_state_t state;
  pisf_state_t next_state;
  logic hit;
  logic clearFlags;

  always_comb
  begin
    next_state = state;
    hit = (req.addr == `PISF_ICS_ADDR);
    clearFlags = hit && req.rdStb;
    // a read returns the flags as they stood before the clear
    if (hit && req.rdStb)
    begin
      next_state.rdData = {state.enables, state.flags};
    end
    else if (req.rdStb)
    begin
      next_state.rdData = `PISF_RDATA_RST;
    end
    // low byte is read-only; writes there are dropped
    if (hit && req.wrStb)
    begin
      next_state.enables = req.wrData[`PISF_EN_LSB +: 8]; // RL8
    end
    // set beats the read clear so a coincident event is never lost
    if (clearFlags)
    begin
      next_state.flags = `PISF_FLAG_RST; // RL1 RL2 RL3 RL4 RL5 RL6 RL7
    end
    if (events[`PISF_BIT_RXERR])
    begin
      next_state.flags[`PISF_BIT_RXERR] = 1'h1; // RL1
    end
    if (events[`PISF_BIT_PAGERX])
    begin
      next_state.flags[`PISF_BIT_PAGERX] = 1'h1; // RL2
    end
    if (events[`PISF_BIT_PDFAULT])
    begin
      next_state.flags[`PISF_BIT_PDFAULT] = 1'h1; // RL3
    end
    if (events[`PISF_BIT_LPACK])
    begin
      next_state.flags[`PISF_BIT_LPACK] = 1'h1; // RL4
    end
    if (events[`PISF_BIT_LINKDN])
    begin
      next_state.flags[`PISF_BIT_LINKDN] = 1'h1; // RL5
    end
    if (events[`PISF_BIT_RFAULT])
    begin
      next_state.flags[`PISF_BIT_RFAULT] = 1'h1; // RL6
    end
    if (events[`PISF_BIT_LINKUP])
    begin
      next_state.flags[`PISF_BIT_LINKUP] = 1'h1; // RL7
    end
    if (events[`PISF_BIT_JABBER])
    begin
      next_state.flags[`PISF_BIT_JABBER] = 1'h1;
    end
    next_state.irq = |(next_state.flags & next_state.enables); // RL9
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= '{enables: `PISF_EN_RST, flags: `PISF_FLAG_RST,
                 rdData: `PISF_RDATA_RST, irq: 1'h0};
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rdData = state.rdData;
  assign irq = state.irq;

  a_rxerr_latch: assert property (@(posedge sys_clk) disable iff (rst) // RL1
    events[`PISF_BIT_RXERR] |=> state.flags[`PISF_BIT_RXERR])
    else $error("receive error flag not latched");

  a_rxerr_clear: assert property (@(posedge sys_clk) disable iff (rst) // RL1
    (req.rdStb && req.addr == `PISF_ICS_ADDR && !events[`PISF_BIT_RXERR])
      |=> !state.flags[`PISF_BIT_RXERR])
    else $error("receive error flag not cleared by read");

  a_rxerr_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL1
    (!events[`PISF_BIT_RXERR] && !(req.rdStb && req.addr == `PISF_ICS_ADDR))
      |=> state.flags[`PISF_BIT_RXERR] == $past(state.flags[`PISF_BIT_RXERR]))
    else $error("receive error flag changed without cause");

  a_pagerx_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL2
    (events[`PISF_BIT_PAGERX] && !(req.rdStb && req.addr == `PISF_ICS_ADDR))
      ##1 !(req.rdStb && req.addr == `PISF_ICS_ADDR)
      |=> state.flags[`PISF_BIT_PAGERX] [*1])
    else $error("page received flag lost before read");

  a_pdfault_clear: assert property (@(posedge sys_clk) disable iff (rst) // RL3
    (req.rdStb && req.addr == `PISF_ICS_ADDR && !events[`PISF_BIT_PDFAULT])
      |=> !state.flags[`PISF_BIT_PDFAULT])
    else $error("parallel detect fault flag not cleared by read");

  a_lpack_report: assert property (@(posedge sys_clk) disable iff (rst) // RL4
    (req.rdStb && req.addr == `PISF_ICS_ADDR && state.flags[`PISF_BIT_LPACK])
      |=> rdData[`PISF_BIT_LPACK])
    else $error("partner acknowledge flag not reported on read");

  a_linkdn_setwin: assert property (@(posedge sys_clk) disable iff (rst) // RL5
    (req.rdStb && req.addr == `PISF_ICS_ADDR && events[`PISF_BIT_LINKDN])
      |=> state.flags[`PISF_BIT_LINKDN])
    else $error("link down event lost during read clear");

  a_rfault_stable: assert property (@(posedge sys_clk) disable iff (rst) // RL6
    (!events[`PISF_BIT_RFAULT] && !(req.rdStb && req.addr == `PISF_ICS_ADDR))
      |=> state.flags[`PISF_BIT_RFAULT] == $past(state.flags[`PISF_BIT_RFAULT]))
    else $error("remote fault flag changed without cause");

  a_linkup_cycle: assert property (@(posedge sys_clk) disable iff (rst) // RL7
    (events[`PISF_BIT_LINKUP] ##1 (req.rdStb && req.addr == `PISF_ICS_ADDR
      && !events[`PISF_BIT_LINKUP])) |=> rdData[`PISF_BIT_LINKUP]
      ##0 !state.flags[`PISF_BIT_LINKUP])
    else $error("link up flag read and clear sequence wrong");

  a_enable_write: assert property (@(posedge sys_clk) disable iff (rst) // RL8
    (req.wrStb && req.addr == `PISF_ICS_ADDR)
      |=> state.enables == $past(req.wrData[15:8]))
    else $error("enable byte not written");

  a_irq_follows: assert property (@(posedge sys_clk) disable iff (rst) // RL9
    (|(events & state.enables) && !(req.wrStb && req.addr == `PISF_ICS_ADDR))
      |=> irq)
    else $error("interrupt not raised for enabled event");

  a_irq_drops: assert property (@(posedge sys_clk) disable iff (rst) // RL9
    (req.rdStb && req.addr == `PISF_ICS_ADDR && events == 8'h00)
      |=> !irq)
    else $error("interrupt not removed after read");

  a_pagerx_latch: assert property (@(posedge sys_clk) disable iff (rst) // RL2
    events[`PISF_BIT_PAGERX] |=> state.flags[`PISF_BIT_PAGERX])
    else $error("page received flag not latched");

  a_pagerx_clear: assert property (@(posedge sys_clk) disable iff (rst) // RL2
    (req.rdStb && req.addr == `PISF_ICS_ADDR && !events[`PISF_BIT_PAGERX])
      |=> !state.flags[`PISF_BIT_PAGERX])
    else $error("page received flag not cleared by read");

  a_pdfault_latch: assert property (@(posedge sys_clk) disable iff (rst) // RL3
    events[`PISF_BIT_PDFAULT] |=> state.flags[`PISF_BIT_PDFAULT])
    else $error("parallel detect fault flag not latched");

  a_pdfault_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL3
    (!events[`PISF_BIT_PDFAULT] && !(req.rdStb && req.addr == `PISF_ICS_ADDR))
      |=> state.flags[`PISF_BIT_PDFAULT] == $past(state.flags[`PISF_BIT_PDFAULT]))
    else $error("parallel detect fault flag changed without cause");

  a_lpack_latch: assert property (@(posedge sys_clk) disable iff (rst) // RL4
    events[`PISF_BIT_LPACK] |=> state.flags[`PISF_BIT_LPACK])
    else $error("partner acknowledge flag not latched");

  a_lpack_clear: assert property (@(posedge sys_clk) disable iff (rst) // RL4
    (req.rdStb && req.addr == `PISF_ICS_ADDR && !events[`PISF_BIT_LPACK])
      |=> !state.flags[`PISF_BIT_LPACK])
    else $error("partner acknowledge flag not cleared by read");

  a_linkdn_latch: assert property (@(posedge sys_clk) disable iff (rst) // RL5
    events[`PISF_BIT_LINKDN] |=> state.flags[`PISF_BIT_LINKDN])
    else $error("link down flag not latched");

  a_linkdn_clear: assert property (@(posedge sys_clk) disable iff (rst) // RL5
    (req.rdStb && req.addr == `PISF_ICS_ADDR && !events[`PISF_BIT_LINKDN])
      |=> !state.flags[`PISF_BIT_LINKDN])
    else $error("link down flag not cleared by read");

  a_rfault_latch: assert property (@(posedge sys_clk) disable iff (rst) // RL6
    events[`PISF_BIT_RFAULT] |=> state.flags[`PISF_BIT_RFAULT])
    else $error("remote fault flag not latched");

  a_rfault_clear: assert property (@(posedge sys_clk) disable iff (rst) // RL6
    (req.rdStb && req.addr == `PISF_ICS_ADDR && !events[`PISF_BIT_RFAULT])
      |=> !state.flags[`PISF_BIT_RFAULT])
    else $error("remote fault flag not cleared by read");

  a_linkup_latch: assert property (@(posedge sys_clk) disable iff (rst) // RL7
    events[`PISF_BIT_LINKUP] |=> state.flags[`PISF_BIT_LINKUP])
    else $error("link up flag not latched");

  a_linkup_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL7
    (!events[`PISF_BIT_LINKUP] && !(req.rdStb && req.addr == `PISF_ICS_ADDR))
      |=> state.flags[`PISF_BIT_LINKUP] == $past(state.flags[`PISF_BIT_LINKUP]))
    else $error("link up flag changed without cause");

  a_enable_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL8
    !(req.wrStb && req.addr == `PISF_ICS_ADDR)
      |=> state.enables == $past(state.enables))
    else $error("enable byte changed without a write");

  a_enable_report: assert property (@(posedge sys_clk) disable iff (rst) // RL8
    (req.rdStb && req.addr == `PISF_ICS_ADDR)
      |=> rdData[15:8] == $past(state.enables))
    else $error("enable byte not reported on read");

  a_rdata_hold: assert property (@(posedge sys_clk) disable iff (rst) // RL8
    !req.rdStb |=> rdData == $past(rdData))
    else $error("read data changed without a read");

  a_irq_quiet: assert property (@(posedge sys_clk) disable iff (rst) // RL9
    (state.enables == 8'h00 && !(req.wrStb && req.addr == `PISF_ICS_ADDR))
      |=> !irq)
    else $error("interrupt raised with every source disabled");
endmodule

// file: include/pisf_consts.svh
`ifndef PISF_CONSTS_SVH
`define PISF_CONSTS_SVH

`define PISF_ICS_ADDR 5'h1B
`define PISF_FLAG_LSB 0
`define PISF_EN_LSB 8
`define PISF_BIT_LINKUP 0
`define PISF_BIT_RFAULT 1
`define PISF_BIT_LINKDN 2
`define PISF_BIT_LPACK 3
`define PISF_BIT_PDFAULT 4
`define PISF_BIT_PAGERX 5
`define PISF_BIT_RXERR 6
`define PISF_BIT_JABBER 7
`define PISF_FLAG_RST 8'h00
`define PISF_EN_RST 8'h00
`define PISF_RDATA_RST 16'h0000

`endif

// file: include/pisf_pkg.sv
package pisf_pkg;
  typedef logic [7:0] pisf_evt_t;

  typedef struct packed {
    logic [4:0] addr;
    logic rdStb;
    logic wrStb;
    logic [15:0] wrData;
  } pisf_req_t;

  typedef struct packed {
    logic [7:0] enables;
    logic [7:0] flags;
    logic [15:0] rdData;
    logic irq;
  } pisf_state_t;
endpackage

// file: bench/pisf_mgmt_model.sv
module pisf_mgmt_model
(
  input wire logic sys_clk,
  output pisf_pkg::pisf_req_t req,
  input wire logic [15:0] rdData
);
  timeunit 1ns;
  timeprecision 1ns;
  import pisf_pkg::*;
  initial req = '0;
  // one access, strobe high for exactly the edge that takes it
  task automatic xfer(input logic [4:0] a, input logic rd, input logic [15:0] d,
    output logic [15:0] q);
    @(posedge sys_clk);
    req <= '{a, rd, !rd, d};
    @(posedge sys_clk);
    req <= '0;
    #1 q = rdData;
  endtask
endmodule

// file: bench/pisf_status_flags_tb_top.sv
module pisf_status_flags_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pisf_pkg::*;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  pisf_evt_t events = 8'h00;
  pisf_req_t req;
  logic [15:0] rdData;
  logic [15:0] q;
  logic irq;
  int errorCnt = 0;
  int compares = 0;
  int cyc = 0;
  initial forever #50 sys_clk = ~sys_clk;
  pisf_status_flags i_pisf_status_flags(.sys_clk(sys_clk), .rst(rst), .events(events),
    .req(req), .rdData(rdData), .irq(irq));
  pisf_mgmt_model i_pisf_mgmt_model(.sys_clk(sys_clk), .req(req), .rdData(rdData));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errorCnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (errorCnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic pulse(input int b);
    @(posedge sys_clk);
    events <= 8'h01 << b;
    @(posedge sys_clk);
    events <= 8'h00;
    #1;
  endtask
  // whole run needs well under 200 cycles
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      errorCnt++;
      wrap_up();
    end
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'h0;
    i_pisf_mgmt_model.xfer(5'h1B, 1'h1, 16'h0000, q);
    chk(q, 16'h0000);
    // low byte is status only, so a write there must not stick
    i_pisf_mgmt_model.xfer(5'h1B, 1'h0, 16'hFF7F, q);
    chk(q, 16'h0000);
    i_pisf_mgmt_model.xfer(5'h1B, 1'h1, 16'h0000, q);
    chk(q, 16'hFF00);
    for (int b = 0; b < 8; b++)
    begin
      pulse(b);
      chk({15'h0000, irq}, 16'h0001);
      i_pisf_mgmt_model.xfer(5'h1B, 1'h1, 16'h0000, q);
      chk(q, 16'hFF00 | (16'h0001 << b));
      chk({15'h0000, irq}, 16'h0000);
      i_pisf_mgmt_model.xfer(5'h1B, 1'h1, 16'h0000, q);
      chk(q, 16'hFF00);
    end
    // an event on the clearing read's edge must survive the clear
    fork
      pulse(2);
      i_pisf_mgmt_model.xfer(5'h1B, 1'h1, 16'h0000, q);
    join
    chk(q, 16'hFF00);
    chk({15'h0000, irq}, 16'h0001);
    i_pisf_mgmt_model.xfer(5'h1B, 1'h1, 16'h0000, q);
    chk(q, 16'hFF04);
    i_pisf_mgmt_model.xfer(5'h1B, 1'h0, 16'h0000, q);
    pulse(1);
    chk({15'h0000, irq}, 16'h0000);
    i_pisf_mgmt_model.xfer(5'h1A, 1'h1, 16'h0000, q);
    chk(q, 16'h0000);
    i_pisf_mgmt_model.xfer(5'h1B, 1'h0, 16'h0100, q);
    chk({15'h0000, irq}, 16'h0000);
    i_pisf_mgmt_model.xfer(5'h1B, 1'h0, 16'h0200, q);
    chk({15'h0000, irq}, 16'h0001);
    i_pisf_mgmt_model.xfer(5'h1B, 1'h1, 16'h0000, q);
    chk(q, 16'h0202);
    chk({15'h0000, irq}, 16'h0000);
    // reset in mid-run drops flags, enables and the interrupt
    i_pisf_mgmt_model.xfer(5'h1B, 1'h0, 16'h0100, q);
    pulse(0);
    chk({15'h0000, irq}, 16'h0001);
    @(posedge sys_clk);
    rst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    chk({15'h0000, irq}, 16'h0000);
    rst <= 1'h0;
    i_pisf_mgmt_model.xfer(5'h1B, 1'h1, 16'h0000, q);
    chk(q, 16'h0000);
    wrap_up();
  end
endmodule
